// [lmv_core.sv]
`timescale 1ns/1ps
module lmv_core
   import lmv_pkg::*;
(
   input  wire logic               clk_in,
   input  wire logic               nrst_in,
   input  wire logic               valid_in,
   input  wire lmv_cmd_type        cmd_in,
   input  wire logic [MEM_AW-1:0]  rd_addr_in,
   output logic      [DATA_W-1:0]  rd_data_out,
   output logic      [BANK_W-1:0]  bank_sel_out,
   output logic      [PAGE_W-1:0]  page_latch_out,
   output logic      [DATA_W-1:0]  acc_out,
   output logic      [PTR_W-1:0]   ptr0_out,
   output logic      [PTR_W-1:0]   ptr1_out,
   output logic      [FLAG_W-1:0]  flags_out,
   output lmv_wr_type              wr_out
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic [BANK_W-1:0] bank_selection_register;
   logic [PAGE_W-1:0] program_counter_high_latch;
   logic [DATA_W-1:0] accumulator;
   logic [PTR_W-1:0]  indirect_pointer [NPTR];
   logic [FLAG_W-1:0] flags;
   lmv_wr_type        wr_last;

   logic [PTR_W-1:0]  sel_ptr;
   logic [PTR_W-1:0]  ofs_ext;
   logic [PTR_W-1:0]  next_addr;
   logic [PTR_W-1:0]  next_ptr;
   logic              file_redirect;
   logic              do_write;
   logic [PTR_W-1:0]  write_addr;
   logic              step_ptr;
   logic              step_idx;

   assign sel_ptr = indirect_pointer[cmd_in.ptr_sel];
   assign ofs_ext = {{(PTR_W-OFS_W){cmd_in.offset[OFS_W-1]}}, cmd_in.offset};

   // ****************************************************************
   // Indirect address and pointer arithmetic
   // ****************************************************************
   always_comb begin
      next_addr = sel_ptr;
      next_ptr  = sel_ptr;
      if (cmd_in.relative) begin
         next_addr = sel_ptr + ofs_ext;
      end else begin
         case (cmd_in.mode)
            MODE_PREINC: begin
               next_addr = sel_ptr + PTR_ONE;
               next_ptr  = sel_ptr + PTR_ONE;
            end
            MODE_PREDEC: begin
               next_addr = sel_ptr - PTR_ONE;
               next_ptr  = sel_ptr - PTR_ONE;
            end
            MODE_POSTINC: begin
               next_addr = sel_ptr;
               next_ptr  = sel_ptr + PTR_ONE;
            end
            MODE_POSTDEC: begin
               next_addr = sel_ptr;
               next_ptr  = sel_ptr - PTR_ONE;
            end
            default: begin
               next_addr = sel_ptr;
               next_ptr  = sel_ptr;
            end
         endcase
      end
   end

   assign file_redirect = (cmd_in.faddr == IND0_ADDR) ||
                          (cmd_in.faddr == IND1_ADDR);

   // ****************************************************************
   // Write port selection
   // ****************************************************************
   always_comb begin
      do_write   = 1'b0;
      write_addr = PTR_RST;
      step_ptr   = 1'b0;
      step_idx   = cmd_in.ptr_sel;
      if (valid_in) begin
         case (cmd_in.op)
            OP_ACC_FILE: begin
               do_write = 1'b1;
               if (file_redirect) begin
                  write_addr = indirect_pointer[cmd_in.faddr[0]];
               end else begin
                  write_addr = {{(PTR_W-FADDR_W){1'b0}}, cmd_in.faddr};
               end
            end
            OP_ACC_IND: begin
               do_write   = 1'b1;
               write_addr = next_addr;
               step_ptr   = !cmd_in.relative;
            end
            default: begin
               do_write   = 1'b0;
               write_addr = PTR_RST;
            end
         endcase
      end
   end

   // ****************************************************************
   // Core registers
   // ****************************************************************
   // bank literal load
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bank_selection_register <= BANK_RST;
      end else if (valid_in && cmd_in.op == OP_BANK_LIT) begin
         bank_selection_register <= cmd_in.lit[BANK_W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         program_counter_high_latch <= PAGE_RST;
      end else if (valid_in && cmd_in.op == OP_PAGE_LIT) begin
         program_counter_high_latch <= cmd_in.lit[PAGE_W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         accumulator <= ACC_RST;
      end else if (valid_in && cmd_in.op == OP_ACC_LIT) begin
         accumulator <= cmd_in.lit;
      end
   end

   // Flags change only on an explicit load from the rest of the core.
   // flags loaded here on OP_FLAG_LOAD
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flags <= FLAG_RST;
      end else if (valid_in && cmd_in.op == OP_FLAG_LOAD) begin
         flags <= cmd_in.lit[FLAG_W-1:0];
      end
   end

   // A redirected direct store may hit a pointer, but pointers hold
   // addresses, not data, so the store lands in memory and no pointer.
   for (genvar i = 0; i < NPTR; i++) begin : g_ptr
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            indirect_pointer[i] <= PTR_RST;
         end else if (valid_in && cmd_in.op == OP_PTR_LOAD &&
                      cmd_in.ptr_sel == 1'(i)) begin
            indirect_pointer[i] <= cmd_in.ptr_value;
         end else if (step_ptr && step_idx == 1'(i)) begin
            indirect_pointer[i] <= next_ptr;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_last <= '0;
      end else begin
         wr_last.strobe <= do_write;
         if (do_write) begin
            wr_last.addr <= write_addr;
            wr_last.data <= accumulator;
         end
      end
   end

   // Only the low address bits reach the on-chip store; higher pointer
   // values alias, and the full address is visible on the write port.
   lmv_mem u_mem (
      .clk_in    (clk_in),
      .we_in     (do_write),
      .waddr_in  (write_addr[MEM_AW-1:0]),
      .wdata_in  (accumulator),
      .raddr_in  (rd_addr_in),
      .rdata_out (rd_data_out)
   );

   assign bank_sel_out   = bank_selection_register;
   assign page_latch_out = program_counter_high_latch;
   assign acc_out        = accumulator;
   assign ptr0_out       = indirect_pointer[0];
   assign ptr1_out       = indirect_pointer[1];
   assign flags_out      = flags;
   assign wr_out         = wr_last;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   logic is_ind;
   assign is_ind = valid_in && cmd_in.op == OP_ACC_IND;

   property p_bank_load;
      valid_in && cmd_in.op == OP_BANK_LIT |=>
         bank_sel_out == $past(cmd_in.lit[BANK_W-1:0]) && $stable(flags_out);
   endproperty
   a_bank_load: assert property (p_bank_load)
      else $error("bank literal not loaded");

   property p_page_load;
      valid_in && cmd_in.op == OP_PAGE_LIT |=>
         page_latch_out == $past(cmd_in.lit[PAGE_W-1:0]) ##1
         page_latch_out == $past(page_latch_out) || $past(valid_in);
   endproperty
   a_page_load: assert property (p_page_load)
      else $error("page latch literal not loaded");

   property p_acc_load;
      valid_in && cmd_in.op == OP_ACC_LIT |=>
         acc_out == $past(cmd_in.lit) && !wr_out.strobe;
   endproperty
   a_acc_load: assert property (p_acc_load)
      else $error("accumulator literal not loaded");

   property p_file_store;
      valid_in && cmd_in.op == OP_ACC_FILE && !file_redirect |=>
         wr_out.strobe && wr_out.data == $past(acc_out) &&
         wr_out.addr == {{(PTR_W-FADDR_W){1'b0}}, $past(cmd_in.faddr)};
   endproperty
   a_file_store: assert property (p_file_store)
      else $error("file store wrong");

   property p_pre_addr;
      is_ind && !cmd_in.relative && cmd_in.mode == MODE_PREINC |=>
         wr_out.addr == $past(sel_ptr) + PTR_ONE;
   endproperty
   a_pre_addr: assert property (p_pre_addr)
      else $error("preincrement address wrong");

   property p_rel_keep;
      is_ind && cmd_in.relative && cmd_in.op == OP_ACC_IND |=>
         wr_out.addr == $past(sel_ptr) + $past(ofs_ext) &&
         $stable(ptr0_out) && $stable(ptr1_out);
   endproperty
   a_rel_keep: assert property (p_rel_keep)
      else $error("relative store moved pointer");

   property p_wrap;
      is_ind && !cmd_in.relative && !cmd_in.ptr_sel &&
      cmd_in.mode == MODE_POSTINC && ptr0_out == '1 |=>
         ptr0_out == PTR_RST;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("pointer did not wrap to zero");

   property p_flags_hold;
      is_ind |=> $stable(flags_out);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("indirect store changed flags");

   property p_redirect;
      valid_in && cmd_in.op == OP_ACC_FILE && cmd_in.faddr == IND1_ADDR |=>
         wr_out.addr == $past(ptr1_out);
   endproperty
   a_redirect: assert property (p_redirect)
      else $error("indirect location not redirected");

   property p_post_order;
      is_ind && !cmd_in.relative && !cmd_in.ptr_sel &&
      cmd_in.mode == MODE_POSTDEC |=>
         wr_out.addr == $past(ptr0_out) &&
         ptr0_out == $past(ptr0_out) - PTR_ONE;
   endproperty
   a_post_order: assert property (p_post_order)
      else $error("postdecrement order wrong");

   c_preinc:  cover property (is_ind && cmd_in.mode == MODE_PREINC);
   c_relneg:  cover property (is_ind && cmd_in.relative &&
                              cmd_in.offset[OFS_W-1]);
   c_redir:   cover property (valid_in && cmd_in.op == OP_ACC_FILE &&
                              file_redirect);
   c_wrapdn:  cover property (is_ind && cmd_in.mode == MODE_POSTDEC &&
                              sel_ptr == PTR_RST);

endmodule

// [lmv_mem.sv]
`timescale 1ns/1ps
module lmv_mem
   import lmv_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              we_in,
   input  wire logic [MEM_AW-1:0] waddr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic [MEM_AW-1:0] raddr_in,
   output logic      [DATA_W-1:0] rdata_out
);

   logic [DATA_W-1:0] store [2**MEM_AW];

   // Contents are not reset; software initialises data memory itself.
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         store[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      rdata_out <= store[raddr_in];
   end

endmodule

// [lmv_pkg.sv]
// Function
// - Bank literal loads bank register, flags untouched.
// - Page literal loads high latch, flags untouched.
// - Accumulator literal loads working register, one cycle.
// - Working register stored to addressed file register.
// - Indirect store address from pointer and mode.
// - Pointer stepped by one, unchanged when relative.
// - Pointer arithmetic wraps at sixteen bits.
// - Pointer updates never touch status flags.
// - Indirect location redirects to pointer address.
package lmv_pkg;

   // ****************************************************************
   // Widths and reset values
   // ****************************************************************
   localparam int BANK_W  = 5;
   localparam int PAGE_W  = 7;
   localparam int DATA_W  = 8;
   localparam int FADDR_W = 7;
   localparam int PTR_W   = 16;
   localparam int OFS_W   = 6;
   localparam int FLAG_W  = 3;
   localparam int NPTR    = 2;
   localparam int MEM_AW  = 7;

   localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
   localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
   localparam logic [PTR_W-1:0]  PTR_ONE  = 16'h0001;
   localparam logic [FLAG_W-1:0] FLAG_RST = 3'h0;

   // ****************************************************************
   // File addresses of the two indirect data locations
   // ****************************************************************
   localparam logic [FADDR_W-1:0] IND0_ADDR = 7'h00;
   localparam logic [FADDR_W-1:0] IND1_ADDR = 7'h01;

   // ****************************************************************
   // Pointer update mode field encodings
   // ****************************************************************
   localparam logic [1:0] MODE_PREINC  = 2'h0;
   localparam logic [1:0] MODE_PREDEC  = 2'h1;
   localparam logic [1:0] MODE_POSTINC = 2'h2;
   localparam logic [1:0] MODE_POSTDEC = 2'h3;

   // ****************************************************************
   // Decoded instruction carrier
   // ****************************************************************
   typedef enum logic [2:0] {
      OP_NOP,
      OP_BANK_LIT,
      OP_PAGE_LIT,
      OP_ACC_LIT,
      OP_ACC_FILE,
      OP_ACC_IND,
      OP_PTR_LOAD,
      OP_FLAG_LOAD
   } lmv_op_type;

   typedef struct packed {
      lmv_op_type         op;
      logic [DATA_W-1:0]  lit;
      logic [FADDR_W-1:0] faddr;
      logic               ptr_sel;
      logic               relative;
      logic [1:0]         mode;
      logic [OFS_W-1:0]   offset;
      logic [PTR_W-1:0]   ptr_value;
   } lmv_cmd_type;

   typedef struct packed {
      logic               strobe;
      logic [PTR_W-1:0]   addr;
      logic [DATA_W-1:0]  data;
   } lmv_wr_type;

endpackage

// [test_literal_and_indirect_moves.sv]
`timescale 1ns/1ps
module test_literal_and_indirect_moves
   import lmv_pkg::*;
;
   logic              clk_in;
   logic              nrst_in;
   logic              valid_in;
   lmv_cmd_type       cmd_in;
   logic [MEM_AW-1:0] rd_addr_in;
   logic [DATA_W-1:0] rd_data_out;
   logic [BANK_W-1:0] bank_sel_out;
   logic [PAGE_W-1:0] page_latch_out;
   logic [DATA_W-1:0] acc_out;
   logic [PTR_W-1:0]  ptr0_out;
   logic [PTR_W-1:0]  ptr1_out;
   logic [FLAG_W-1:0] flags_out;
   lmv_wr_type        wr_out;

   int                fail_count = 0;
   int                n_checks = 0;
   int                cycles = 0;
   integer            seed = 84419;
   logic [BANK_W-1:0] e_bank;
   logic [PAGE_W-1:0] e_page;
   logic [DATA_W-1:0] e_acc;
   logic [PTR_W-1:0]  e_ptr [NPTR];
   logic [FLAG_W-1:0] e_flags;
   lmv_wr_type        e_wr;
   logic [DATA_W-1:0] mem [128];
   bit                known [128];
   lmv_cmd_type       c;

   lmv_core u_lmv_core (
      .clk_in         (clk_in),
      .nrst_in        (nrst_in),
      .valid_in       (valid_in),
      .cmd_in         (cmd_in),
      .rd_addr_in     (rd_addr_in),
      .rd_data_out    (rd_data_out),
      .bank_sel_out   (bank_sel_out),
      .page_latch_out (page_latch_out),
      .acc_out        (acc_out),
      .ptr0_out       (ptr0_out),
      .ptr1_out       (ptr1_out),
      .flags_out      (flags_out),
      .wr_out         (wr_out)
   );

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // ***************************************************************
   // Expectation helpers
   // ***************************************************************
   // access address, post modes use old pointer.
   function automatic logic [PTR_W-1:0] ind_addr(logic [PTR_W-1:0] p,
                                                 lmv_cmd_type k);
      if (k.relative)
         return p + {{(PTR_W-OFS_W){k.offset[OFS_W-1]}}, k.offset};
      case (k.mode)
         MODE_PREINC: return p + PTR_ONE;
         MODE_PREDEC: return p - PTR_ONE;
         default:     return p;
      endcase
   endfunction

   // pointer steps by one with wrap, kept when relative.
   function automatic logic [PTR_W-1:0] ind_next(logic [PTR_W-1:0] p,
                                                 lmv_cmd_type k);
      if (k.relative)
         return p;
      if (k.mode == MODE_PREINC || k.mode == MODE_POSTINC)
         return p + PTR_ONE;
      return p - PTR_ONE;
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic store(input logic [PTR_W-1:0] a);
      e_wr.strobe = 1'b1;
      e_wr.addr = a;
      e_wr.data = e_acc;
      mem[a[MEM_AW-1:0]] = e_acc;
      known[a[MEM_AW-1:0]] = 1'b1;
   endtask

   // ***************************************************************
   // One instruction slot, checked after its edge
   // ***************************************************************
   task automatic go(input lmv_cmd_type k, input logic v);
      logic [PTR_W-1:0] a;
      valid_in = v;
      cmd_in = k;
      e_wr.strobe = 1'b0;
      if (v) begin
         case (k.op)
            OP_BANK_LIT:  e_bank = k.lit[BANK_W-1:0];
            OP_PAGE_LIT:  e_page = k.lit[PAGE_W-1:0];
            OP_ACC_LIT:   e_acc = k.lit;
            OP_PTR_LOAD:  e_ptr[k.ptr_sel] = k.ptr_value;
            OP_FLAG_LOAD: e_flags = k.lit[FLAG_W-1:0];
            OP_ACC_FILE: begin
               a = {{(PTR_W-FADDR_W){1'b0}}, k.faddr};
               if (k.faddr == IND0_ADDR) a = e_ptr[0];
               if (k.faddr == IND1_ADDR) a = e_ptr[1];
               store(a);
            end
            OP_ACC_IND: begin
               store(ind_addr(e_ptr[k.ptr_sel], k));
               e_ptr[k.ptr_sel] = ind_next(e_ptr[k.ptr_sel], k);
            end
            default: ;
         endcase
      end
      @(posedge clk_in);
      @(negedge clk_in);
      chk(16'(bank_sel_out), 16'(e_bank));
      chk(16'(page_latch_out), 16'(e_page));
      chk(16'(acc_out), 16'(e_acc));
      chk(ptr0_out, e_ptr[0]);
      chk(ptr1_out, e_ptr[1]);
      chk(16'(flags_out), 16'(e_flags));
      chk(16'(wr_out.strobe), 16'(e_wr.strobe));
      chk(wr_out.addr, e_wr.addr);
      chk(16'(wr_out.data), 16'(e_wr.data));
   endtask

   task automatic op(input lmv_op_type o, input logic [7:0] lit,
                     input logic [6:0] fa, input logic ps,
                     input logic rel, input logic [1:0] md,
                     input logic [5:0] ofs, input logic [15:0] pv);
      c = '{o, lit, fa, ps, rel, md, ofs, pv};
      go(c, 1'b1);
   endtask

   task automatic do_reset();
      @(negedge clk_in);
      nrst_in = 1'b0;
      valid_in = 1'b0;
      repeat (6) @(negedge clk_in);
      e_bank = BANK_RST;
      e_page = PAGE_RST;
      e_acc = ACC_RST;
      e_ptr[0] = PTR_RST;
      e_ptr[1] = PTR_RST;
      e_flags = FLAG_RST;
      e_wr = '0;
      nrst_in = 1'b1;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         summarize();
      end
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      nrst_in = 1'b0;
      valid_in = 1'b0;
      cmd_in = '0;
      rd_addr_in = '0;
      do_reset();
      go('0, 1'b0);
      op(OP_ACC_LIT, 8'h5A, 7'h00, 0, 0, 2'h0, 6'h00, 16'h0000);
      op(OP_BANK_LIT, 8'h1F, 7'h00, 0, 0, 2'h0, 6'h00, 16'h0000);
      op(OP_PAGE_LIT, 8'h7F, 7'h00, 0, 0, 2'h0, 6'h00, 16'h0000);
      op(OP_FLAG_LOAD, 8'h07, 7'h00, 0, 0, 2'h0, 6'h00, 16'h0000);
      op(OP_PTR_LOAD, 8'h00, 7'h00, 0, 0, 2'h0, 6'h00, 16'hFFFF);
      op(OP_ACC_IND, 8'h00, 7'h00, 0, 0, MODE_POSTINC, 6'h00, 16'h0);
      op(OP_ACC_IND, 8'h00, 7'h00, 1, 0, MODE_PREDEC, 6'h00, 16'h0);
      op(OP_ACC_IND, 8'h00, 7'h00, 1, 0, MODE_PREINC, 6'h00, 16'h0);
      op(OP_ACC_IND, 8'h00, 7'h00, 0, 0, MODE_POSTDEC, 6'h00, 16'h0);
      op(OP_PTR_LOAD, 8'h00, 7'h00, 1, 0, 2'h0, 6'h00, 16'h0040);
      op(OP_ACC_IND, 8'h00, 7'h00, 1, 1, MODE_PREINC, 6'h20, 16'h0);
      op(OP_ACC_IND, 8'h00, 7'h00, 1, 1, MODE_POSTDEC, 6'h1F, 16'h0);
      op(OP_ACC_FILE, 8'h00, IND0_ADDR, 0, 0, 2'h0, 6'h00, 16'h0);
      op(OP_ACC_FILE, 8'h00, IND1_ADDR, 0, 0, 2'h0, 6'h00, 16'h0);
      op(OP_ACC_FILE, 8'h00, 7'h7F, 0, 0, 2'h0, 6'h00, 16'h0);
      repeat (400) begin
         c = lmv_cmd_type'({$random(seed), $random(seed)});
         if (c.op == OP_BANK_LIT) c.lit[7:5] = 3'h0;
         if (c.op == OP_PAGE_LIT) c.lit[7] = 1'b0;
         c.faddr[6] = 1'b0;
         go(c, ($random(seed) & 7) != 0);
      end
      valid_in = 1'b0;
      for (int i = 0; i < 128; i++) begin
         if (known[i]) begin
            rd_addr_in = 7'(i);
            @(posedge clk_in);
            @(negedge clk_in);
            chk(16'(rd_data_out), 16'(mem[i]));
         end
      end
      do_reset();
      go('0, 1'b0);
      op(OP_ACC_LIT, 8'hC3, 7'h00, 0, 0, 2'h0, 6'h00, 16'h0000);
      op(OP_ACC_FILE, 8'h00, 7'h10, 0, 0, 2'h0, 6'h00, 16'h0);
      summarize();
   end
endmodule
